// ### common/tbra_pkg.sv
package tbra_pkg;

  // one received byte from the frame decoder
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic crc_ok;
    logic [7:0] data;
  } tbra_rx_t;

  // one answer byte to the frame encoder
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tbra_tx_t;

  typedef enum logic [1:0] {
    TBRA_LISTEN = 2'b01,
    TBRA_ANSWER = 2'b10
  } tbra_state_t;

endpackage : tbra_pkg

// ### common/tbra_regs.svh
`ifndef TBRA_REGS_SVH
`define TBRA_REGS_SVH

// identification command frame layout
`define TBRA_CMD_CODE 8'h05
`define TBRA_CMD_LEN 3'h5
`define TBRA_POS_CODE 3'h0
`define TBRA_POS_AFI 3'h1
`define TBRA_POS_PARAM 3'h2
`define TBRA_PARAM_WAKE_BIT 3
`define TBRA_PARAM_SLOT_HI 2
`define TBRA_PARAM_SLOT_LO 0

// answer layout, crc trailer appended by the framer
`define TBRA_ANS_CODE 8'h50
`define TBRA_ANS_APP 32'h0000_0000
`define TBRA_ANS_PROT1 8'h91
`define TBRA_ANS_PROT2 8'h81
`define TBRA_ANS_PROT3_LO 4'h0
`define TBRA_ANS_LEN 4'hc
`define TBRA_ANS_LAST 4'hb

// reader guard time after the answer: 10 etu + 32 subcarrier periods
`define TBRA_GUARD_ETU 10
`define TBRA_GUARD_FS_PERIODS 32
`define TBRA_FS_KHZ 848

`endif

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, nrst, tag_idle, tag_halt, slow, tx_ready;
  logic answer_done, wake_from_halt;
  tbra_pkg::tbra_rx_t rx;
  tbra_pkg::tbra_tx_t tx;
  logic [31:0] pupi = 32'ha1b2c3d4;
  logic [3:0] fwi;
  logic [7:0] rx_afi;
  logic [95:0] e;
  logic [7:0] pr[6] = '{8'he7, 8'h00, 8'h0c, 8'h08, 8'h00, 8'h00};
  logic [5:0] kv = 6'h2f, iv = 6'h39, hv = 6'h06, av = 6'h0d, wv = 6'h04;
  int fails, comparisons, ad, wk;
  tbra_top dut (.*);
  tbra_sink r (.*);
  always @(posedge mclk)
  begin
    ad += answer_done;
    wk += wake_from_halt;
  end
  task close_out;
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // five byte frame: code, afi, param, two crc bytes
  task send(input logic [7:0] c, input logic [7:0] p, input logic k);
    logic [7:0] b[5];
    b = '{c, 8'h3c, p, 8'h11, 8'h22};
    for (int j = 0; j < 5; j++)
    begin
      @(posedge mclk) #1;
      rx = '{1'b1, j == 0, j == 4, k && j == 4, b[j]};
    end
    @(posedge mclk) #1;
    rx = '0;
  endtask : send
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    #4000;
    fails++;
    close_out;
  end
  initial
  begin
    nrst = 0; rx = '0; tag_idle = 0; tag_halt = 0; slow = 0; fwi = 0;
    repeat (3) @(posedge mclk);
    #1 nrst = 1;
    for (int i = 0; i < 6; i++)
    begin
      tag_idle = iv[i]; tag_halt = hv[i]; slow = i == 0; fwi = 4'(i + 3);
      r.got.delete(); ad = 0; wk = 0;
      e = {8'h50, pupi, 32'h0, 8'h91, 8'h81, fwi, 4'h0};
      send(i == 5 ? 8'h06 : 8'h05, pr[i], kv[i]);
      repeat (60) @(posedge mclk);
      chk(ad == av[i] && wk == wv[i], "answer");
      chk(r.got.size() == 12 * av[i], "length");
      foreach (r.got[j]) chk(r.got[j] === e[95 - 8 * j -: 8], "byte");
      chk(rx_afi === 8'h3c, "afi");
    end
    close_out;
  end
endmodule : tb

// ### tb/tbra_checker.sv
`timescale 1ns/1ps
module tbra_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire tbra_pkg::tbra_rx_t rx,
  input wire logic [31:0] pupi,
  input wire logic [3:0] fwi,
  input wire tbra_pkg::tbra_tx_t tx,
  input wire logic tx_ready,
  input wire logic answer_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [3:0] n;
  always_ff @(posedge mclk)
  begin
    if (!tx.valid) n <= 4'h0;
    else if (tx_ready) n <= n + 4'h1;
  end
  AST_CODE: assert property (tx.valid && n == 0 |-> tx.data == 8'h50)
    else $error("bad answer code");
  AST_ID: assert property (tx.valid && n == 1 |-> tx.data == pupi[31:24])
    else $error("bad id byte");
  AST_APP: assert property (tx.valid && n inside {[5:8]} |-> tx.data == 0)
    else $error("bad app byte");
  AST_P1: assert property (tx.valid && n == 9 |-> tx.data == 8'h91)
    else $error("bad info byte 1");
  AST_P2: assert property (tx.valid && n == 10 |-> tx.data == 8'h81)
    else $error("bad info byte 2");
  AST_P3: assert property (tx.valid && n == 11 |-> tx.data == {fwi, 4'h0})
    else $error("bad info byte 3");
  AST_LAST: assert property (tx.valid |-> tx.last == (n == 11))
    else $error("bad last flag");
  AST_DONE: assert property (tx.valid && tx.last && tx_ready |=> answer_done && !tx.valid)
    else $error("bad end of answer");
  AST_HOLD: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
    else $error("byte dropped");
  AST_CRC: assert property (rx.valid && rx.eof && !rx.crc_ok && !tx.valid |=> !tx.valid)
    else $error("answer on bad crc");
endmodule : tbra_chk
bind tbra_top tbra_chk c (
  .mclk(mclk),
  .nrst(nrst),
  .rx(rx),
  .pupi(pupi),
  .fwi(fwi),
  .tx(tx),
  .tx_ready(tx_ready),
  .answer_done(answer_done)
);

// ### tb/tbra_sink.sv
`timescale 1ns/1ps
module tbra_sink (
  input wire logic mclk,
  input wire tbra_pkg::tbra_tx_t tx,
  input wire logic slow,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic t = 1'b0;
  // slow mode stalls every other cycle to exercise the hold
  assign tx_ready = !slow || t;
  always @(posedge mclk)
  begin
    if (tx.valid && tx_ready) got.push_back(tx.data);
    t <= ~t;
  end
endmodule : tbra_sink

// ### verilog/tbra_top.sv
`timescale 1ns/1ps
`include "tbra_regs.svh"
// Function
// - request variant is accepted while the tag is idle
// - wake-up variant is accepted while halted and also while idle
// - parameter bits 7 to 5 are ignored
// - slot count field ignored, always one slot, answer at once
// - answer: 0x50, four id bytes, four app bytes, three info, crc
// - all four application data bytes are zero
// - first protocol info byte is 0x91
// - second protocol info byte is 0x81
// - third info byte: frame waiting integer high, low nibble zero
module tbra_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire tbra_pkg::tbra_rx_t rx,
  input wire logic tag_idle,
  input wire logic tag_halt,
  input wire logic [31:0] pupi,
  input wire logic [3:0] fwi,
  output tbra_pkg::tbra_tx_t tx,
  input wire logic tx_ready,
  output logic [7:0] rx_afi,
  output logic wake_from_halt,
  output logic answer_done
);

  tbra_pkg::tbra_state_t state;
  tbra_pkg::tbra_state_t next_state;
  logic [2:0] rx_count;
  logic rx_overlong;
  logic [7:0] rx_code;
  logic [7:0] rx_param;
  logic [3:0] tx_index;
  logic [7:0] tx_data;
  logic tx_valid;

  wire rx_take = rx.valid && state == tbra_pkg::TBRA_LISTEN;
  // a start-of-frame byte taken while listening restarts the count
  wire [2:0] byte_pos = rx.sof ? 3'h0 : rx_count;
  wire [2:0] next_count = byte_pos + 3'h1;
  wire [7:0] cur_code = byte_pos == `TBRA_POS_CODE ? rx.data : rx_code;
  wire [7:0] cur_param = byte_pos == `TBRA_POS_PARAM ? rx.data : rx_param;
  wire too_long = !rx.sof && (rx_overlong || rx_count == `TBRA_CMD_LEN);

  // only code, length and crc qualify the frame; param bits 7-5 and
  // the slot field are never looked at
  wire crc_good = rx.eof && rx.crc_ok;
  wire len_ok = !too_long && next_count == `TBRA_CMD_LEN;
  wire code_ok = cur_code == `TBRA_CMD_CODE;
  wire frame_ok = rx_take && crc_good && len_ok && code_ok;
  wire is_wake = cur_param[`TBRA_PARAM_WAKE_BIT];
  wire accept_req = frame_ok && !is_wake && tag_idle;
  wire accept_wake = frame_ok && is_wake && (tag_idle || tag_halt);
  wire accept = accept_req || accept_wake;

  // answer bytes in send order; the crc trailer is added by the encoder
  wire [7:0] ans_id0 = pupi[31:24];
  wire [7:0] ans_id1 = pupi[23:16];
  wire [7:0] ans_id2 = pupi[15:8];
  wire [7:0] ans_id3 = pupi[7:0];
  wire [31:0] ans_app = `TBRA_ANS_APP;
  wire [7:0] ans_app0 = ans_app[31:24];
  wire [7:0] ans_app1 = ans_app[23:16];
  wire [7:0] ans_app2 = ans_app[15:8];
  wire [7:0] ans_app3 = ans_app[7:0];
  wire [7:0] ans_prot3 = {fwi, `TBRA_ANS_PROT3_LO};

  wire tx_fire = tx_valid && tx_ready;
  wire tx_end = tx_fire && tx_index == `TBRA_ANS_LAST;
  wire tx_last = tx_valid && tx_index == `TBRA_ANS_LAST;
  wire [3:0] tx_step = tx_index + 4'h1;
  // the index parks at zero between answers so the byte lane never
  // selects past the last byte
  wire [3:0] next_index = (accept || tx_end) ? 4'h0
    : (tx_fire ? tx_step : tx_index);
  logic [7:0] next_byte;

  always_comb
  begin
    next_byte = 8'h00;
    case (next_index)
      4'h0:
        next_byte = `TBRA_ANS_CODE;
      4'h1:
        next_byte = ans_id0;
      4'h2:
        next_byte = ans_id1;
      4'h3:
        next_byte = ans_id2;
      4'h4:
        next_byte = ans_id3;
      4'h5:
        next_byte = ans_app0;
      4'h6:
        next_byte = ans_app1;
      4'h7:
        next_byte = ans_app2;
      4'h8:
        next_byte = ans_app3;
      4'h9:
        next_byte = `TBRA_ANS_PROT1;
      4'ha:
        next_byte = `TBRA_ANS_PROT2;
      4'hb:
        next_byte = ans_prot3;
      default:
        next_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      tbra_pkg::TBRA_LISTEN:
      begin
        if (accept)
          next_state = tbra_pkg::TBRA_ANSWER;
      end
      tbra_pkg::TBRA_ANSWER:
      begin
        if (tx_end)
          next_state = tbra_pkg::TBRA_LISTEN;
      end
      default:
        next_state = tbra_pkg::TBRA_LISTEN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      state <= tbra_pkg::TBRA_LISTEN;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_count <= 3'h0;
      rx_overlong <= 1'b0;
    end
    else if (rx_take)
    begin
      // count wraps would alias a long frame onto a short one
      rx_count <= rx.eof ? 3'h0 : (too_long ? rx_count : next_count);
      rx_overlong <= rx.eof ? 1'b0 : too_long;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_code <= 8'h00;
      rx_param <= 8'h00;
    end
    else if (rx_take)
    begin
      rx_code <= cur_code;
      rx_param <= cur_param;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rx_afi <= 8'h00;
    else if (rx_take && byte_pos == `TBRA_POS_AFI)
      rx_afi <= rx.data;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tx_valid <= 1'b0;
      tx_index <= 4'h0;
    end
    else
    begin
      tx_valid <= accept || (tx_valid && !tx_end);
      tx_index <= next_index;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      tx_data <= 8'h00;
    else
      tx_data <= next_byte;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      wake_from_halt <= 1'b0;
    else
      wake_from_halt <= accept_wake && !tag_idle;
  end

  // the reader guard time that follows is the reader's duty
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      answer_done <= 1'b0;
    else
      answer_done <= tx_end;
  end

  assign tx = '{valid: tx_valid, last: tx_last, data: tx_data};

endmodule : tbra_top
